// File: hw/sleep_wake_ctrl.sv
module sleep_wake_ctrl (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Core side
  input wire logic wfi_exec,
  input wire logic wfe_exec,
  input wire logic sev_exec,
  input wire logic last_handler_return,
  input wire logic debug_wake,
  // Interrupt controller side
  input wire logic exc_entry_ok,
  input wire logic irq_above_level,
  input wire logic new_pending,
  input wire logic priority_mask_bit,
  input wire logic fault_mask_bit,
  // Clock control and core status
  output logic core_clk_en,
  output logic sys_clk_en,
  output logic pll_power_down,
  output logic flash_power_down,
  output logic sleeping,
  output logic wfe_continue,
  output logic handler_defer,
  output logic irq
);
  sleep_link_if lnk ();
  sleep_pkg::pwr_state_t state; // Current power state
  sleep_pkg::pwr_state_t next_state;
  logic by_wfe; // Sleep was entered by wait for event
  logic next_by_wfe;
  logic consume; // Clear the event latch this cycle
  logic enter; // Sleep entry this cycle
  logic skip; // Wait for event passed over
  logic woke; // Leaving sleep this cycle
  logic [sleep_pkg::CTRL_W-1:0] system_control_reg;
  logic [sleep_pkg::INT_W-1:0] int_status; // Sticky events
  logic [sleep_pkg::INT_W-1:0] int_mask; // Irq enables
  logic wr_pend; // Write data phase pending
  logic [7:0] wr_addr; // Write target offset

  // Hookup of shared wires
  assign lnk.exc_ok = exc_entry_ok;
  assign lnk.irq_higher = irq_above_level;
  assign lnk.pmask = priority_mask_bit;
  assign lnk.fmask = fault_mask_bit;
  assign lnk.new_pend = new_pending;
  assign lnk.evt_pend_en = system_control_reg[sleep_pkg::EVT_PEND_POS];
  assign lnk.send_event_instr = sev_exec;
  assign lnk.dbg = debug_wake;
  assign lnk.consume = consume;

  event_latch u_latch (
    .hclk(hclk),
    .hresetn(hresetn),
    .lnk(lnk.latch)
  );

  wake_detect u_detect (
    .lnk(lnk.detect)
  );

  // Control bit decode
  wire deep_sleep_select = system_control_reg[sleep_pkg::DEEP_SEL_POS];
  wire sleep_after_exit = system_control_reg[sleep_pkg::SLEEP_EXIT_POS];
  wire asleep = (state != sleep_pkg::RUN);
  // Mode for a fresh sleep entry
  wire sleep_pkg::pwr_state_t entry_mode = deep_sleep_select ? sleep_pkg::DEEP : sleep_pkg::LIGHT;

  // Sequencer next state
  always_comb
  begin
    next_state = state;
    next_by_wfe = by_wfe;
    consume = 1'b0;
    enter = 1'b0;
    skip = 1'b0;
    woke = 1'b0;
    case (state)
      sleep_pkg::RUN:
      begin
        // Wait for interrupt wins over the others
        if (wfi_exec)
        begin
          // A wake already true keeps the core running
          enter = ~lnk.wake_int;
          next_by_wfe = 1'b0;
        end
        else if (wfe_exec)
        begin
          if (lnk.evt_held)
          begin
            // Latch set: clear and fall through
            consume = 1'b1;
            skip = 1'b1;
          end
          else
          begin
            enter = 1'b1;
            next_by_wfe = 1'b1;
          end
        end
        else if (last_handler_return && sleep_after_exit)
        begin
          // Back to thread level and straight to sleep
          enter = 1'b1;
          next_by_wfe = 1'b0;
        end
        if (enter)
          next_state = entry_mode;
      end
      sleep_pkg::LIGHT, sleep_pkg::DEEP:
      begin
        // Event wakes only count for event sleep
        if (lnk.wake_int || (by_wfe && lnk.wake_evt))
        begin
          next_state = sleep_pkg::RUN;
          woke = 1'b1;
          // A latched event is used up on any wake from event sleep
          consume = by_wfe & lnk.evt_held;
        end
      end
      default:
        next_state = sleep_pkg::RUN;
    endcase
  end

  // Wake with nothing but debug behind it
  wire spurious = woke & debug_wake & ~exc_entry_ok & ~lnk.defer_wake & ~(by_wfe & lnk.wake_evt);
  // Handler hold lasts while the priority mask stays set
  wire next_defer = (woke & lnk.defer_wake) | (handler_defer & priority_mask_bit);

  // State and clock gate registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= sleep_pkg::RUN;
      by_wfe <= 1'b0;
      core_clk_en <= 1'b1;
      sys_clk_en <= 1'b1;
      pll_power_down <= 1'b0;
      flash_power_down <= 1'b0;
      sleeping <= 1'b0;
      wfe_continue <= 1'b0;
      handler_defer <= 1'b0;
    end
    else
    begin
      state <= next_state;
      by_wfe <= next_by_wfe;
      core_clk_en <= (next_state == sleep_pkg::RUN);
      sys_clk_en <= (next_state != sleep_pkg::DEEP);
      pll_power_down <= (next_state == sleep_pkg::DEEP);
      flash_power_down <= (next_state == sleep_pkg::DEEP);
      sleeping <= (next_state != sleep_pkg::RUN);
      wfe_continue <= skip;
      handler_defer <= next_defer;
    end
  end

  // Bus decode: taken address phase
  wire addr_ok = hsel & htrans[1] & hready;
  wire [7:0] ofs = haddr[7:0];
  wire wr_ctrl = wr_pend & (wr_addr == sleep_pkg::CTRL_OFS);
  wire wr_stat = wr_pend & (wr_addr == sleep_pkg::INT_STAT_OFS);
  wire wr_mask = wr_pend & (wr_addr == sleep_pkg::INT_MASK_OFS);
  // Live state word for software; latch stays hidden
  wire [31:0] state_word = {28'h0000000, handler_defer, by_wfe, state};
  // Read mux, unmapped reads give zero
  wire [31:0] rd_mux =
    (ofs == sleep_pkg::CTRL_OFS) ? {29'h00000000, system_control_reg} :
    (ofs == sleep_pkg::STATE_OFS) ? state_word :
    (ofs == sleep_pkg::INT_STAT_OFS) ? {28'h0000000, int_status} :
    (ofs == sleep_pkg::INT_MASK_OFS) ? {28'h0000000, int_mask} : 32'h00000000;
  // Events raised this cycle
  wire [sleep_pkg::INT_W-1:0] int_set = {skip, spurious, woke, enter};
  // Write one to clear, but a new event wins
  wire [sleep_pkg::INT_W-1:0] w1c = wr_stat ? hwdata[sleep_pkg::INT_W-1:0] : 4'h0;
  wire [sleep_pkg::INT_W-1:0] next_int_status = int_set | (int_status & ~w1c);
  // Mask as it will stand, so irq never lags a mask write
  wire [sleep_pkg::INT_W-1:0] next_int_mask = wr_mask ? hwdata[sleep_pkg::INT_W-1:0] : int_mask;

  // Bus slave registers; zero wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= sleep_pkg::HRESP_OKAY;
    end
    else
    begin
      wr_pend <= addr_ok & hwrite;
      wr_addr <= ofs;
      // Read data sampled at the address edge
      if (addr_ok && !hwrite)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp <= sleep_pkg::HRESP_OKAY;
    end
  end

  // Software controlled registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      system_control_reg <= sleep_pkg::CTRL_RESET;
      int_mask <= sleep_pkg::INT_MASK_RESET;
      int_status <= 4'h0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        system_control_reg <= hwdata[sleep_pkg::CTRL_W-1:0];
      int_mask <= next_int_mask;
      int_status <= next_int_status;
      // Level irq follows registered status and mask
      irq <= |(next_int_status & next_int_mask);
    end
  end

  // Checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  light_gate_a: assert property (state == sleep_pkg::LIGHT |-> !core_clk_en && sys_clk_en && !pll_power_down)
    else $error("light sleep gates wrong clocks");
  deep_gate_a: assert property (state == sleep_pkg::DEEP |-> !sys_clk_en && pll_power_down && flash_power_down)
    else $error("deep sleep leaves clocks running");
  mode_select_a: assert property (!asleep && wfi_exec && !lnk.wake_int |=>
    (state == sleep_pkg::DEEP) == $past(deep_sleep_select))
    else $error("sleep mode does not follow deep select");
  wfi_hold_a: assert property (!asleep && wfi_exec && lnk.wake_int |=> !asleep && core_clk_en)
    else $error("wait for interrupt slept with wake pending");
  wfe_sleep_a: assert property (!asleep && !wfi_exec && wfe_exec && !lnk.evt_held |=> asleep && by_wfe)
    else $error("wait for event did not sleep");
  wfe_skip_a: assert property (!asleep && !wfi_exec && wfe_exec && lnk.evt_held && !sev_exec
    |=> !asleep && wfe_continue ##1 !wfe_continue)
    else $error("wait for event skip wrong");
  exit_sleep_a: assert property (!asleep && !wfi_exec && !wfe_exec && last_handler_return && sleep_after_exit
    |=> asleep && !by_wfe)
    else $error("sleep after exit missed");
  exc_wake_a: assert property (asleep && exc_entry_ok |=> !asleep ##0 core_clk_en)
    else $error("exception did not wake core");
  pend_wake_a: assert property (asleep && by_wfe && lnk.evt_pend_en && new_pending |=> !asleep)
    else $error("pending event did not wake core");
  defer_hold_a: assert property (handler_defer && priority_mask_bit |=> handler_defer)
    else $error("handler deferral dropped early");
  irq_level_a: assert property (irq == |(int_status & int_mask))
    else $error("irq does not match unmasked status");
endmodule : sleep_wake_ctrl

// File: hw/sleep_pkg.sv
package sleep_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] INT_STAT_OFS = 8'h08;
  localparam logic [7:0] INT_MASK_OFS = 8'h0C;
  // Control register fields
  localparam int CTRL_W = 3;
  localparam int SLEEP_EXIT_POS = 0;
  localparam int DEEP_SEL_POS = 1;
  localparam int EVT_PEND_POS = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;
  // Interrupt status and mask fields
  localparam int INT_W = 4;
  localparam int INT_ENTER_POS = 0;
  localparam int INT_WAKE_POS = 1;
  localparam int INT_SPUR_POS = 2;
  localparam int INT_SKIP_POS = 3;
  localparam logic [INT_W-1:0] INT_MASK_RESET = 4'h0;
  // State register fields
  localparam int ST_MODE_POS = 0;
  localparam int ST_BY_WFE_POS = 2;
  localparam int ST_DEFER_POS = 3;
  // Bus answer codes
  localparam logic HRESP_OKAY = 1'b0;
  // Power states of the core
  typedef enum logic [1:0] {RUN, LIGHT, DEEP} pwr_state_t;
endpackage : sleep_pkg

// File: hw/sleep_link_if.sv
// Wires between the sequencer, the event latch and the wake detector
interface sleep_link_if;
  logic exc_ok;      // Exception priority enough for entry
  logic irq_higher;  // Enabled irq above current level
  logic pmask;       // Priority mask bit
  logic fmask;       // Fault mask bit
  logic new_pend;    // Newly pending interrupt pulse
  logic evt_pend_en; // Event on pending enable
  logic send_event_instr;         // Send event executed
  logic dbg;         // Debug wake request
  logic consume;     // Latch cleared by wait for event
  logic evt_held;    // Hidden event latch value
  logic wake_int;    // Wake for any sleep entry
  logic wake_evt;    // Extra wake for event sleep
  logic defer_wake;  // Wake whose handler waits on mask
  modport ctrl (output exc_ok, irq_higher, pmask, fmask, new_pend, evt_pend_en, send_event_instr, dbg, consume,
    input evt_held, wake_int, wake_evt, defer_wake);
  modport latch (input send_event_instr, new_pend, evt_pend_en, consume, output evt_held);
  modport detect (input exc_ok, irq_higher, pmask, fmask, new_pend, evt_pend_en, dbg, evt_held,
    output wake_int, wake_evt, defer_wake);
endinterface : sleep_link_if

// File: hw/event_latch.sv
// One-bit event latch, invisible to software
module event_latch (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Link to sequencer
  sleep_link_if.latch lnk
);
  logic held;
  // Pending interrupt counts as an event when enabled
  wire set_evt = lnk.send_event_instr | (lnk.evt_pend_en & lnk.new_pend);
  // Set beats consume so no event is lost
  wire next_held = set_evt | (held & ~lnk.consume);

  // Latch storage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      held <= 1'b0;
    else
      held <= next_held;
  end

  assign lnk.evt_held = held;

  sev_sets_a: assert property (@(posedge hclk) disable iff (!hresetn) lnk.send_event_instr |=> held)
    else $error("event latch not set by send event");
endmodule : event_latch

// File: hw/wake_detect.sv
// Wake conditions from the interrupt controller and debug
module wake_detect (
  sleep_link_if.detect lnk
);
  // Masked wake: handler held back until priority mask clears
  assign lnk.defer_wake = lnk.pmask & ~lnk.fmask & lnk.irq_higher;
  // Any sleep ends on enough priority, deferred irq or debug
  assign lnk.wake_int = lnk.exc_ok | lnk.defer_wake | lnk.dbg;
  // Event sleep also ends on latch or, when enabled, new pending irq
  assign lnk.wake_evt = lnk.evt_held | (lnk.evt_pend_en & lnk.new_pend);
endmodule : wake_detect

// File: dv/core_side_model.sv
// Core and interrupt controller as seen by the sequencer
module core_side_model (
  // Clock
  input wire logic hclk,
  // Core instructions
  output logic wfi_exec,
  output logic wfe_exec,
  output logic sev_exec,
  output logic last_handler_return,
  // Controller levels and pulses
  output logic new_pending,
  output logic fault_mask_bit,
  output logic priority_mask_bit,
  output logic irq_above_level,
  output logic exc_entry_ok,
  output logic debug_wake
);
  timeunit 1ns;
  timeprecision 1ns;
  // Quiet at time zero
  initial
  begin
    {wfi_exec, wfe_exec, sev_exec, last_handler_return} = 4'h0;
    {new_pending, fault_mask_bit, priority_mask_bit, irq_above_level, exc_entry_ok, debug_wake} = 6'h00;
  end
  // One instruction per call: 0 wait irq, 1 wait event, 2 handler exit, 3 send event
  task instr(input logic [1:0] op);
    @(posedge hclk);
    wfi_exec <= (op == 2'h0);
    wfe_exec <= (op == 2'h1);
    last_handler_return <= (op == 2'h2);
    sev_exec <= (op == 2'h3);
    @(posedge hclk);
    {wfi_exec, wfe_exec, sev_exec, last_handler_return} <= 4'h0;
  endtask : instr
  // Wake inputs for one cycle, then all low again
  task levels(input logic [5:0] wk);
    @(posedge hclk);
    new_pending <= wk[5];
    fault_mask_bit <= wk[4];
    priority_mask_bit <= wk[3];
    irq_above_level <= wk[2];
    exc_entry_ok <= wk[1];
    debug_wake <= wk[0];
    @(posedge hclk);
    {new_pending, fault_mask_bit, priority_mask_bit, irq_above_level, exc_entry_ok, debug_wake} <= 6'h00;
  endtask : levels
  // Exception level held until changed again
  task exc_level(input logic v);
    exc_entry_ok <= v;
  endtask : exc_level
endmodule : core_side_model

// File: dv/processor_sleep_wake_control_test.sv
// Self-checking bench for the sleep and wake sequencer
module processor_sleep_wake_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  // Bus and control wires
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic wfi_exec, wfe_exec, sev_exec, last_handler_return, debug_wake;
  logic exc_entry_ok, irq_above_level, new_pending, priority_mask_bit, fault_mask_bit;
  logic core_clk_en, sys_clk_en, pll_power_down, flash_power_down, sleeping, wfe_continue, handler_defer, irq;
  int failures = 0;
  int compares = 0;
  // Row: control value, instruction, wake inputs, slept, woke, deferred
  typedef struct packed {logic [2:0] ctrl; logic [1:0] op; logic [5:0] wk; logic sl; logic wo; logic df;} case_row_t;
  // Wake bits: pending, fault mask, priority mask, irq above, exception ok, debug
  // Pending wake comes last: the waking event leaves the latch set
  case_row_t rows [11] = '{'{3'h0, 2'h0, 6'h02, 1'b1, 1'b1, 1'b0}, '{3'h2, 2'h0, 6'h02, 1'b1, 1'b1, 1'b0},
    '{3'h0, 2'h0, 6'h20, 1'b1, 1'b0, 1'b0},
    '{3'h0, 2'h1, 6'h20, 1'b1, 1'b0, 1'b0}, '{3'h0, 2'h1, 6'h02, 1'b1, 1'b1, 1'b0},
    '{3'h1, 2'h2, 6'h02, 1'b1, 1'b1, 1'b0}, '{3'h0, 2'h2, 6'h00, 1'b0, 1'b0, 1'b0},
    '{3'h0, 2'h0, 6'h0C, 1'b1, 1'b1, 1'b1}, '{3'h0, 2'h0, 6'h1C, 1'b1, 1'b0, 1'b0},
    '{3'h6, 2'h1, 6'h01, 1'b1, 1'b1, 1'b0}, '{3'h4, 2'h1, 6'h20, 1'b1, 1'b1, 1'b0}};
  // Design under test, single slave so hready is its own ready
  sleep_wake_ctrl dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .wfi_exec, .wfe_exec, .sev_exec, .last_handler_return, .debug_wake,
    .exc_entry_ok, .irq_above_level, .new_pending, .priority_mask_bit, .fault_mask_bit, .core_clk_en,
    .sys_clk_en, .pll_power_down, .flash_power_down, .sleeping, .wfe_continue, .handler_defer, .irq);
  // Far side of the core interface
  core_side_model model (.hclk, .wfi_exec, .wfe_exec, .sev_exec, .last_handler_return, .new_pending,
    .fault_mask_bit, .priority_mask_bit, .irq_above_level, .exc_entry_ok, .debug_wake);
  // Clock at 100 MHz
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // Bit and word comparisons
  task chk1(input string n, input logic e, input logic s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, s);
    end
  endtask : chk1
  task chk32(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk32
  // One AHB-Lite single word transfer; waits on ready with no fixed count
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask : bus
  // Counts and verdict
  task wrap_up;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // Hang guard, far beyond the few hundred cycles of the run
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end
  // Main sequence
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    #1;
    chk1("core_clk_en", 1'b1, core_clk_en);
    chk1("sys_clk_en", 1'b1, sys_clk_en);
    @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, unmapped place, read-only state
    for (int a = 0; a < 5; a++)
    begin
      bus(1'b0, 8'(a * 4), 32'h0, rd);
      chk32("reset word", 32'h0, rd);
    end
    chk1("hreadyout", 1'b1, hreadyout);
    chk1("hresp", sleep_pkg::HRESP_OKAY, hresp);
    bus(1'b1, 8'h10, 32'hFFFFFFFF, rd);
    bus(1'b1, sleep_pkg::STATE_OFS, 32'hFFFFFFFF, rd);
    bus(1'b1, sleep_pkg::CTRL_OFS, 32'hFFFFFFFF, rd);
    bus(1'b0, 8'h10, 32'h0, rd);
    chk32("unmapped", 32'h0, rd);
    bus(1'b0, sleep_pkg::STATE_OFS, 32'h0, rd);
    chk32("state", 32'h0, rd);
    bus(1'b0, sleep_pkg::CTRL_OFS, 32'h0, rd);
    chk32("control", 32'h7, rd);
    $display("test registers done");
    // Table of entries and wakes
    for (int i = 0; i < 11; i++)
    begin
      bus(1'b1, sleep_pkg::CTRL_OFS, {29'h0, rows[i].ctrl}, rd);
      model.instr(rows[i].op);
      #1;
      chk1("sleeping", rows[i].sl, sleeping);
      chk1("core_clk_en", !rows[i].sl, core_clk_en);
      chk1("sys_clk_en", !(rows[i].sl & rows[i].ctrl[1]), sys_clk_en);
      chk1("pll_power_down", rows[i].sl & rows[i].ctrl[1], pll_power_down);
      chk1("flash_power_down", rows[i].sl & rows[i].ctrl[1], flash_power_down);
      model.levels(rows[i].wk);
      #1;
      chk1("woken", rows[i].sl & !rows[i].wo, sleeping);
      chk1("handler_defer", rows[i].df, handler_defer);
      if (sleeping === 1'b1)
        model.levels(6'h02);
      @(posedge hclk);
      #1;
      chk1("defer released", 1'b0, handler_defer);
    end
    $display("test table done");
    // Refused wait with wake pending, then send event passes over one wait
    bus(1'b1, sleep_pkg::CTRL_OFS, 32'h0, rd);
    model.exc_level(1'b1);
    model.instr(2'h0);
    #1;
    chk1("sleeping", 1'b0, sleeping);
    model.exc_level(1'b0);
    model.instr(2'h1);
    #1;
    chk1("wfe_continue", 1'b1, wfe_continue);
    model.instr(2'h3);
    model.instr(2'h1);
    #1;
    chk1("sleeping", 1'b0, sleeping);
    chk1("wfe_continue", 1'b1, wfe_continue);
    model.instr(2'h1);
    #1;
    chk1("sleeping", 1'b1, sleeping);
    model.levels(6'h02);
    $display("test event latch done");
    // Status, mask and the interrupt line
    bus(1'b1, sleep_pkg::INT_STAT_OFS, 32'hF, rd);
    bus(1'b1, sleep_pkg::INT_MASK_OFS, 32'hF, rd);
    bus(1'b0, sleep_pkg::INT_STAT_OFS, 32'h0, rd);
    chk32("status cleared", 32'h0, rd);
    model.instr(2'h0);
    model.levels(6'h01);
    model.instr(2'h3);
    model.instr(2'h1);
    bus(1'b0, sleep_pkg::INT_STAT_OFS, 32'h0, rd);
    chk32("status", 32'hF, rd);
    chk1("irq", 1'b1, irq);
    bus(1'b1, sleep_pkg::INT_STAT_OFS, 32'h5, rd);
    bus(1'b0, sleep_pkg::INT_STAT_OFS, 32'h0, rd);
    chk32("status", 32'hA, rd);
    bus(1'b1, sleep_pkg::INT_MASK_OFS, 32'h0, rd);
    @(posedge hclk);
    #1;
    chk1("irq masked", 1'b0, irq);
    $display("test interrupt done");
    // Deep event sleep seen in state, then reset in mid sleep
    bus(1'b1, sleep_pkg::CTRL_OFS, 32'h2, rd);
    model.instr(2'h1);
    bus(1'b0, sleep_pkg::STATE_OFS, 32'h0, rd);
    chk32("state", 32'h6, rd);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(posedge hclk);
    #1;
    chk1("sys_clk_en", 1'b1, sys_clk_en);
    chk1("sleeping", 1'b0, sleeping);
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, sleep_pkg::CTRL_OFS, 32'h0, rd);
    chk32("control", 32'h0, rd);
    $display("test mid reset done");
    wrap_up();
  end
endmodule : processor_sleep_wake_control_test
